// ---- pkg/tlb_pkg.sv ----
// Shared constants and types for the loopback and self-test channel.
// Assumes both channel ends and the bench import it whole.
package tlb_pkg;
  // Data path and buffer sizes, reference clock and PLL counts.
  localparam int TLB_DW         = 20;
  localparam int TLB_FIFO_DEPTH = 16;
  localparam int TLB_NUM_TRANSCEIVER_REFERENCE_CLOCK = 2;
  localparam int TLB_NUM_TX_PLL = 2;
  localparam int TLB_NUM_RX_PLL = 4;

  // Pattern generator: state width, tap positions and reset seed.
  localparam int         TLB_ST_W      = 10;
  localparam int         TLB_P7_TAP_A  = 6;
  localparam int         TLB_P7_TAP_B  = 5;
  localparam int         TLB_P10_TAP_A = 9;
  localparam int         TLB_P10_TAP_B = 6;
  localparam int         TLB_NB_W20    = 20;
  localparam int         TLB_NB_W10    = 10;
  localparam logic [9:0] TLB_SEED_RST  = 10'h3FF;

  // Clock source codes for every clock multiplexer.
  localparam int         TLB_CS_W      = 4;
  localparam logic [3:0] TLB_CS_REF0   = 4'h0;
  localparam logic [3:0] TLB_CS_REF1   = 4'h1;
  localparam logic [3:0] TLB_CS_TXPLL0 = 4'h2;
  localparam logic [3:0] TLB_CS_TXPLL1 = 4'h3;
  localparam logic [3:0] TLB_CS_GCLK   = 4'h4;
  localparam logic [3:0] TLB_CS_IQ     = 4'h5;
  localparam logic [3:0] TLB_CS_RXPLL0 = 4'h6;
  localparam logic [3:0] TLB_CS_RXPLL3 = 4'h9;
  localparam logic [3:0] TLB_CS_RST    = 4'h0;

  // Resolved loopback path of the channel.
  typedef enum logic [2:0] {
    TLB_LB_NONE,
    TLB_LB_SERIAL,
    TLB_LB_PARALLEL,
    TLB_LB_REV_SERIAL,
    TLB_LB_REV_PRECDR,
    TLB_LB_PIPE_REV_PAR
  } tlb_lb_e;

  // Static loopback choice made at configuration time.
  typedef enum logic [1:0] {
    TLB_CFG_NONE,
    TLB_CFG_PARALLEL,
    TLB_CFG_REV_SERIAL,
    TLB_CFG_REV_PRECDR
  } tlb_lbcfg_e;
endpackage

// ---- pkg/tlb_if.sv ----
// Interface joining the fabric logic end and the transceiver channel end.
// Assumes both ends share ref_clk; no clocking block is used.
interface tlb_if
  import tlb_pkg::*;
#(
  parameter int DW = TLB_DW
);
  logic [DW-1:0] tx_data;
  logic          tx_valid;
  logic          tx_ready;
  logic [DW-1:0] rx_data;
  logic          rx_valid;
  logic          ser_lpbk_en;
  logic          pipe_lpbk;
  logic          gclk_pin_src;
  logic          bist_err;
  logic          bist_lock;
  tlb_lb_e       lb_active;

  // Transceiver channel end.
  modport dev (
    input  tx_data, tx_valid, ser_lpbk_en, pipe_lpbk, gclk_pin_src,
    output tx_ready, rx_data, rx_valid, bist_err, bist_lock, lb_active
  );

  // Fabric logic end.
  modport fab (
    output tx_data, tx_valid, ser_lpbk_en, pipe_lpbk, gclk_pin_src,
    input  tx_ready, rx_data, rx_valid, bist_err, bist_lock, lb_active
  );
endinterface

// ---- hw/tlb_xcvr.sv ----
// Transceiver channel end: transmit FIFO, loopback path selection,
// pattern generator and verifier, and clock route selection.
// Assumes the fabric end drives the interface synchronously to ref_clk.
//
// Notes on behaviour
// RL1 - Serial loopback switched at run time per channel.
// RL2 - No serial loopback in PIPE mode.
// RL3 - Serial loopback exercises all but input buffer.
// RL4 - Fabric supplies transmit data in serial loopback.
// RL5 - Self-test mode generates and checks pattern internally.
// RL6 - Twenty-bit width uses seven-stage pattern.
// RL7 - Ten-bit width uses ten-stage pattern.
// RL8 - Parallel loopback only Basic double-width.
// RL9 - Parallel loopback transmits generator data.
// RL10 - Parallel loopback returns data before analog stage.
// RL11 - Verifier reports mismatches during parallel loopback.
// RL12 - Reverse serial retransmits retimed received stream.
// RL13 - Pre-recovery reverse loop returns unretimed signal.
// RL14 - PIPE reverse loop only in PIPE, run time.
// RL15 - Two transmit, four receive PLLs, either reference.
// RL16 - Transmit PLL feeds global, regional or receive PLL.
// RL17 - One reference clock per quad drives inter-quad.
// RL18 - Global clock for PLLs comes from pin.
// RL19 - Receive PLL clock routes to adjacent regional.
// RL20 - One loopback path active; requests resolve.

// Synchronous FIFO with registered full and empty flags.
module tlb_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16
) (
  // Clock, reset and enable.
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          full_r;
  logic          empty_r;
  logic          push;
  logic          pop;

  // Transfers happen only on accepted handshakes.
  assign push      = ce && in_valid && !full_r;
  assign pop       = ce && out_ready && !empty_r;
  assign in_ready  = !full_r;
  assign out_valid = !empty_r;
  assign out_data  = mem[rd_ptr_r];
  assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  // Storage array write.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, fill level and flags.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      full_r   <= 1'b0;
      empty_r  <= 1'b1;
    end else if (ce) begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      cnt_r    <= cnt_nxt;
      full_r   <= (cnt_nxt == FULL_CNT);
      empty_r  <= (cnt_nxt == '0);
    end
  end
endmodule

module tlb_xcvr
  import tlb_pkg::*;
#(
  parameter int DW    = TLB_DW,
  parameter int DEPTH = TLB_FIFO_DEPTH
) (
  // Clock, reset and enable.
  input  wire logic    ref_clk,
  input  wire logic    rst_b,
  input  wire logic    ce,
  // Fabric side.
  tlb_if.dev           lnk,
  // Channel configuration.
  input  wire logic    cfg_pipe_mode,
  input  wire logic    cfg_double_width,
  input  wire logic    cfg_width20,
  input  wire logic    cfg_bist_en,
  input  tlb_lbcfg_e   cfg_lb,
  // Serial line side.
  input  wire logic [DW-1:0] ser_rx_word,
  input  wire logic          ser_rx_valid,
  input  wire logic          ser_tx_ready,
  output logic [DW-1:0]      ser_tx_word_r,
  output logic               ser_tx_vld_r,
  // Clock route requests.
  input  wire logic [TLB_NUM_TX_PLL-1:0][TLB_CS_W-1:0] clk_tx_pll_src,
  input  wire logic [TLB_NUM_RX_PLL-1:0][TLB_CS_W-1:0] clk_rx_pll_src,
  input  wire logic [TLB_CS_W-1:0]                     clk_gclk_src,
  input  wire logic [TLB_CS_W-1:0]                     clk_rclk_src,
  input  wire logic                                    clk_iq_en,
  input  wire logic                                    clk_iq_ref,
  // Clock route selections in force.
  output logic [TLB_NUM_TX_PLL-1:0][TLB_CS_W-1:0] clk_tx_pll_sel_r,
  output logic [TLB_NUM_RX_PLL-1:0][TLB_CS_W-1:0] clk_rx_pll_sel_r,
  output logic [TLB_CS_W-1:0]                     clk_gclk_sel_r,
  output logic [TLB_CS_W-1:0]                     clk_rclk_sel_r,
  output logic [TLB_NUM_TRANSCEIVER_REFERENCE_CLOCK-1:0]               clk_iq_drv_r,
  output logic                                    clk_route_err_r
);
  // Resolves all loopback requests to a single path.
  function automatic tlb_lb_e lb_resolve(input logic pipe, input logic dw,
                                         input logic ser, input logic plb,
                                         input tlb_lbcfg_e cfg);
    tlb_lb_e r;
    r = TLB_LB_NONE;
    if (pipe) begin
      if (plb) r = TLB_LB_PIPE_REV_PAR; // RL14
    end else if (ser) begin
      r = TLB_LB_SERIAL; // RL1
    end else if (cfg == TLB_CFG_PARALLEL && dw) begin
      r = TLB_LB_PARALLEL; // RL8
    end else if (cfg == TLB_CFG_REV_SERIAL) begin
      r = TLB_LB_REV_SERIAL;
    end else if (cfg == TLB_CFG_REV_PRECDR) begin
      r = TLB_LB_REV_PRECDR;
    end
    return r; // RL20
  endfunction

  // Advances the pattern one word; returns next state and word bits.
  function automatic logic [TLB_ST_W+DW-1:0] prbs_word(
      input logic [TLB_ST_W-1:0] st, input logic w20);
    logic [TLB_ST_W-1:0] s;
    logic [DW-1:0]       b;
    logic                fb;
    s = st;
    b = '0;
    fb = 1'b0;
    for (int i = 0; i < DW; i++) begin
      if (w20 || i < TLB_NB_W10) begin
        fb = w20 ? (s[TLB_P7_TAP_A] ^ s[TLB_P7_TAP_B]) // RL6
                 : (s[TLB_P10_TAP_A] ^ s[TLB_P10_TAP_B]); // RL7
        b[i] = fb;
        s = {s[TLB_ST_W-2:0], fb};
      end
    end
    return {s, b};
  endfunction

  // Rebuilds the pattern state from the last bits of a word.
  function automatic logic [TLB_ST_W-1:0] prbs_seed(
      input logic [DW-1:0] w, input logic w20);
    logic [TLB_ST_W-1:0] s;
    s = '0;
    for (int k = 0; k < TLB_ST_W; k++) begin
      s[k] = w20 ? w[TLB_NB_W20-1-k] : w[TLB_NB_W10-1-k];
    end
    return s;
  endfunction

  // Source is legal for a PLL reference input.
  function automatic logic pll_src_ok(input logic [TLB_CS_W-1:0] c,
                                      input logic is_rx, input logic pin);
    logic ok;
    ok = (c == TLB_CS_REF0) || (c == TLB_CS_REF1) || (c == TLB_CS_IQ);
    ok = ok || (c == TLB_CS_GCLK && pin); // RL18
    ok = ok || (is_rx && (c == TLB_CS_TXPLL0 || c == TLB_CS_TXPLL1));
    return ok; // RL16
  endfunction

  // Source is legal for a global or regional clock line.
  function automatic logic net_src_ok(input logic [TLB_CS_W-1:0] c);
    return (c <= TLB_CS_TXPLL1) ||
           (c >= TLB_CS_RXPLL0 && c <= TLB_CS_RXPLL3); // RL19
  endfunction

  tlb_lb_e             lb_r;
  logic [TLB_ST_W-1:0] gen_st_r;
  logic [DW-1:0]       ser_lb_r;
  logic                ser_lb_vld_r;
  logic [DW-1:0]       cdr_r;
  logic                cdr_vld_r;
  logic [DW-1:0]       rx_data_r;
  logic                rx_valid_r;
  logic [DW-1:0]       prev_r;
  logic                prev_vld_r;
  logic                bist_err_r;
  logic                bist_lock_r;
  logic [TLB_ST_W+DW-1:0] gen_nxt;
  logic [TLB_ST_W+DW-1:0] exp_nxt;
  logic                gen_act;
  logic                use_fifo;
  logic                fifo_vld;
  logic                fifo_pop;
  logic [DW-1:0]       fifo_data;
  logic [DW-1:0]       pcs_tx;
  logic                pcs_tx_vld;
  logic [DW-1:0]       pcs_rx;
  logic                pcs_rx_vld;
  logic [TLB_NUM_TX_PLL+TLB_NUM_RX_PLL+2:0] err_v;

  // Transmit buffer between fabric and encoder.
  tlb_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (lnk.tx_valid),
    .in_ready  (lnk.tx_ready),
    .in_data   (lnk.tx_data),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Transmit source: generator, returned receive word or fabric data.
  assign gen_act  = (cfg_bist_en && lb_r == TLB_LB_SERIAL) || // RL5
                    lb_r == TLB_LB_PARALLEL; // RL9
  assign use_fifo = !gen_act && lb_r != TLB_LB_PIPE_REV_PAR &&
                    lb_r != TLB_LB_REV_SERIAL && lb_r != TLB_LB_REV_PRECDR;
  assign fifo_pop = use_fifo &&
                    (lb_r == TLB_LB_SERIAL || ser_tx_ready); // RL4
  assign gen_nxt  = prbs_word(gen_st_r, cfg_width20);
  always_comb begin
    if (gen_act) begin
      pcs_tx     = gen_nxt[DW-1:0];
      pcs_tx_vld = 1'b1;
    end else if (lb_r == TLB_LB_PIPE_REV_PAR) begin
      pcs_tx     = cdr_r; // RL14
      pcs_tx_vld = cdr_vld_r;
    end else begin
      pcs_tx     = fifo_data;
      pcs_tx_vld = fifo_vld && fifo_pop;
    end
  end

  // Receive input: coding sublayer return or recovered data.
  assign pcs_rx     = (lb_r == TLB_LB_PARALLEL) ? pcs_tx : cdr_r; // RL10
  assign pcs_rx_vld = (lb_r == TLB_LB_PARALLEL) ? pcs_tx_vld : cdr_vld_r;
  assign exp_nxt    = prbs_word(prbs_seed(prev_r, cfg_width20), cfg_width20);

  // Loopback path register.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lb_r <= TLB_LB_NONE;
    end else if (ce) begin
      lb_r <= lb_resolve(cfg_pipe_mode, cfg_double_width, // RL2
                         lnk.ser_lpbk_en, lnk.pipe_lpbk, cfg_lb);
    end
  end

  // Generator state advances only while it feeds the transmitter.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_st_r <= TLB_SEED_RST;
    end else if (ce && gen_act) begin
      gen_st_r <= gen_nxt[TLB_ST_W+DW-1:DW];
    end
  end

  // Serializer and clock recovery stages of the line path.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_lb_r     <= '0;
      ser_lb_vld_r <= 1'b0;
      cdr_r        <= '0;
      cdr_vld_r    <= 1'b0;
    end else if (ce) begin
      ser_lb_r     <= pcs_tx;
      ser_lb_vld_r <= pcs_tx_vld;
      if (lb_r == TLB_LB_SERIAL) begin
        cdr_r     <= ser_lb_r; // RL3
        cdr_vld_r <= ser_lb_vld_r;
      end else begin
        cdr_r     <= ser_rx_word;
        cdr_vld_r <= ser_rx_valid;
      end
    end
  end

  // Serial output driver.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_tx_word_r <= '0;
      ser_tx_vld_r  <= 1'b0;
    end else if (ce) begin
      unique case (lb_r)
        TLB_LB_REV_SERIAL: begin
          ser_tx_word_r <= cdr_r; // RL12
          ser_tx_vld_r  <= cdr_vld_r;
        end
        TLB_LB_REV_PRECDR: begin
          ser_tx_word_r <= ser_rx_word; // RL13
          ser_tx_vld_r  <= ser_rx_valid;
        end
        default: begin
          ser_tx_word_r <= pcs_tx;
          ser_tx_vld_r  <= pcs_tx_vld;
        end
      endcase
    end
  end

  // Receive data toward the fabric and self-test checking.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_r   <= '0;
      rx_valid_r  <= 1'b0;
      prev_r      <= '0;
      prev_vld_r  <= 1'b0;
      bist_err_r  <= 1'b0;
      bist_lock_r <= 1'b0;
    end else if (ce) begin
      rx_data_r  <= pcs_rx;
      rx_valid_r <= pcs_rx_vld;
      if (!gen_act) begin
        prev_vld_r  <= 1'b0;
        bist_err_r  <= 1'b0;
        bist_lock_r <= 1'b0;
      end else if (pcs_rx_vld) begin
        prev_r     <= pcs_rx;
        prev_vld_r <= 1'b1;
        if (prev_vld_r) begin
          bist_lock_r <= 1'b1;
          if (pcs_rx != exp_nxt[DW-1:0]) begin
            bist_err_r <= 1'b1; // RL11
          end
        end
      end
    end
  end

  assign lnk.rx_data   = rx_data_r;
  assign lnk.rx_valid  = rx_valid_r;
  assign lnk.bist_err  = bist_err_r;
  assign lnk.bist_lock = bist_lock_r;
  assign lnk.lb_active = lb_r;

  // PLL reference selection; an illegal request keeps the old choice.
  for (genvar t = 0; t < TLB_NUM_TX_PLL; t++) begin : g_tx
    assign err_v[t] = !pll_src_ok(clk_tx_pll_src[t], 1'b0,
                                  lnk.gclk_pin_src);
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        clk_tx_pll_sel_r[t] <= TLB_CS_RST;
      end else if (ce && !err_v[t]) begin
        clk_tx_pll_sel_r[t] <= clk_tx_pll_src[t]; // RL15
      end
    end
  end
  for (genvar r = 0; r < TLB_NUM_RX_PLL; r++) begin : g_rx
    assign err_v[TLB_NUM_TX_PLL+r] = !pll_src_ok(clk_rx_pll_src[r], 1'b1,
                                                 lnk.gclk_pin_src);
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        clk_rx_pll_sel_r[r] <= TLB_CS_RST;
      end else if (ce && !err_v[TLB_NUM_TX_PLL+r]) begin
        clk_rx_pll_sel_r[r] <= clk_rx_pll_src[r]; // RL15
      end
    end
  end
  assign err_v[TLB_NUM_TX_PLL+TLB_NUM_RX_PLL]   = !net_src_ok(clk_gclk_src);
  assign err_v[TLB_NUM_TX_PLL+TLB_NUM_RX_PLL+1] = !net_src_ok(clk_rclk_src);
  assign err_v[TLB_NUM_TX_PLL+TLB_NUM_RX_PLL+2] = 1'b0;

  // Global, regional and inter-quad line selection.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_gclk_sel_r  <= TLB_CS_RST;
      clk_rclk_sel_r  <= TLB_CS_RST;
      clk_iq_drv_r    <= '0;
      clk_route_err_r <= 1'b0;
    end else if (ce) begin
      if (!err_v[TLB_NUM_TX_PLL+TLB_NUM_RX_PLL]) begin
        clk_gclk_sel_r <= clk_gclk_src; // RL16
      end
      if (!err_v[TLB_NUM_TX_PLL+TLB_NUM_RX_PLL+1]) begin
        clk_rclk_sel_r <= clk_rclk_src; // RL19
      end
      clk_iq_drv_r    <= clk_iq_en ? {clk_iq_ref, !clk_iq_ref} : '0; // RL17
      clk_route_err_r <= |err_v;
    end
  end
endmodule

// ---- hw/tlb_fabric.sv ----
// Fabric logic end: feeds transmit words, drives loopback requests and
// returns received words and self-test status to the user.
// Assumes the channel end on the interface runs on the same ref_clk.
module tlb_fabric
  import tlb_pkg::*;
#(
  parameter int DW = TLB_DW
) (
  // Clock, reset and enable.
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // Channel side.
  tlb_if.fab                 lnk,
  // User transmit stream.
  input  wire logic [DW-1:0] usr_tx_data,
  input  wire logic          usr_tx_valid,
  output logic               usr_tx_ready_r,
  // User loopback requests.
  input  wire logic          usr_pipe_mode,
  input  wire logic          usr_ser_lpbk_req,
  input  wire logic          usr_pipe_lpbk_req,
  input  wire logic          usr_gclk_from_pin,
  // User receive stream and status.
  output logic [DW-1:0]      usr_rx_data_r,
  output logic               usr_rx_valid_r,
  output logic               usr_bist_err_r,
  output logic               usr_bist_lock_r,
  output tlb_lb_e            usr_lb_r
);
  logic [DW-1:0] hold_r;
  logic          hold_vld_r;
  logic          hold_vld_nxt;
  logic          take;
  logic          ser_en_r;
  logic          pipe_lb_r;
  logic          pin_src_r;

  // One-word holding stage toward the channel FIFO.
  assign take         = usr_tx_valid && usr_tx_ready_r;
  assign hold_vld_nxt = take ||
                        (hold_vld_r && !lnk.tx_ready);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r         <= '0;
      hold_vld_r     <= 1'b0;
      usr_tx_ready_r <= 1'b0;
    end else if (ce) begin
      if (take) begin
        hold_r <= usr_tx_data; // RL4
      end
      hold_vld_r     <= hold_vld_nxt;
      usr_tx_ready_r <= !hold_vld_nxt;
    end
  end

  // Loopback requests and clock source declaration.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_en_r  <= 1'b0;
      pipe_lb_r <= 1'b0;
      pin_src_r <= 1'b0;
    end else if (ce) begin
      ser_en_r  <= usr_ser_lpbk_req && !usr_pipe_mode; // RL1
      pipe_lb_r <= usr_pipe_lpbk_req && usr_pipe_mode; // RL14
      pin_src_r <= usr_gclk_from_pin; // RL18
    end
  end

  assign lnk.tx_data      = hold_r;
  assign lnk.tx_valid     = hold_vld_r;
  assign lnk.ser_lpbk_en  = ser_en_r;
  assign lnk.pipe_lpbk    = pipe_lb_r;
  assign lnk.gclk_pin_src = pin_src_r;

  // Receive words and status toward the user.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      usr_rx_data_r   <= '0;
      usr_rx_valid_r  <= 1'b0;
      usr_bist_err_r  <= 1'b0;
      usr_bist_lock_r <= 1'b0;
      usr_lb_r        <= TLB_LB_NONE;
    end else if (ce) begin
      usr_rx_data_r   <= lnk.rx_data;
      usr_rx_valid_r  <= lnk.rx_valid;
      usr_bist_err_r  <= lnk.bist_err;
      usr_bist_lock_r <= lnk.bist_lock;
      usr_lb_r        <= lnk.lb_active;
    end
  end
endmodule

// ---- tb/tlb_assertions.sv ----
// Checker on the link between the fabric end and the channel end.
// Assumes ce stays high and both ends share ref_clk.
module tlb_assertions
  import tlb_pkg::*;
(
  // Clock and reset.
  input wire logic              ref_clk,
  input wire logic              rst_b,
  // Link signals.
  input wire logic [TLB_DW-1:0] tx_data,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              rx_valid,
  input wire logic              ser_lpbk_en,
  input wire logic              pipe_lpbk,
  input wire logic              bist_err,
  input wire logic              bist_lock,
  input tlb_lb_e                lb_active
);
  timeunit 1ns;
  timeprecision 1ps;

  // All checks share one clock and stay quiet during reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Path resolution follows the requests by one cycle.
  property p_ser; ser_lpbk_en |=> lb_active == TLB_LB_SERIAL; endproperty
  a_ser: assert property (p_ser) else $error("serial path missed");
  property p_ser_src;
    lb_active == TLB_LB_SERIAL |-> $past(ser_lpbk_en) && !$past(pipe_lpbk);
  endproperty
  a_ser_src: assert property (p_ser_src) else $error("serial unasked");
  property p_pipe; pipe_lpbk |=> lb_active == TLB_LB_PIPE_REV_PAR; endproperty
  a_pipe: assert property (p_pipe) else $error("pipe path missed");
  property p_pipe_src;
    lb_active == TLB_LB_PIPE_REV_PAR |-> $past(pipe_lpbk);
  endproperty
  a_pipe_src: assert property (p_pipe_src) else $error("pipe unasked");
  property p_one; lb_active <= TLB_LB_PIPE_REV_PAR; endproperty
  a_one: assert property (p_one) else $error("undefined path");

  // A waiting transmit word is held until the channel takes it.
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("tx word dropped");

  // The parallel self-test loop returns words and locks without errors.
  property p_par_rx; (lb_active == TLB_LB_PARALLEL) [*3] |-> rx_valid;
  endproperty
  a_par_rx: assert property (p_par_rx) else $error("no loop data");
  property p_par_ok;
    (lb_active == TLB_LB_PARALLEL) [*8] |-> bist_lock && !bist_err;
  endproperty
  a_par_ok: assert property (p_par_ok) else $error("self-test bad");
  property p_err_clr; $fell(bist_err) |-> lb_active != TLB_LB_PARALLEL;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error lost");

  // Main scenarios reached.
  c_ser: cover property (lb_active == TLB_LB_SERIAL);
  c_pipe: cover property (lb_active == TLB_LB_PIPE_REV_PAR);
  c_par: cover property ((lb_active == TLB_LB_PARALLEL) [*8]);
endmodule

// ---- tb/tb.sv ----
// Bench joining the fabric end and the channel end over the link.
// Assumes one clock; the bench plays the serial line and the user.
module tb import tlb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic            ref_clk = 1'b0;
  logic            rst_b, ce, pm, dw, w20, be, srv, str, iqe, iqr;
  logic            utv, upm, usr, upr, ugp, utr, urv, ube, ubl, stv, rerr;
  logic [19:0]     utd, srw, stw, urd;
  logic [3:0]      gs, rs, gsel, rsel;
  logic [1:0]      iqd;
  logic [1:0][3:0] txs, txsel;
  logic [3:0][3:0] rxs, rxsel;
  tlb_lbcfg_e      lbc;
  tlb_lb_e         ulb;
  int              err_count, checked, n;

  // Link, both ends and the link checker.
  tlb_if lnk ();
  tlb_fabric tlb_fabric_i (.ref_clk, .rst_b, .ce, .lnk, .usr_tx_data(utd),
    .usr_tx_valid(utv), .usr_tx_ready_r(utr), .usr_pipe_mode(upm),
    .usr_ser_lpbk_req(usr), .usr_pipe_lpbk_req(upr),
    .usr_gclk_from_pin(ugp), .usr_rx_data_r(urd), .usr_rx_valid_r(urv),
    .usr_bist_err_r(ube), .usr_bist_lock_r(ubl), .usr_lb_r(ulb));
  tlb_xcvr tlb_xcvr_i (.ref_clk, .rst_b, .ce, .lnk, .cfg_pipe_mode(pm),
    .cfg_double_width(dw), .cfg_width20(w20), .cfg_bist_en(be),
    .cfg_lb(lbc), .ser_rx_word(srw), .ser_rx_valid(srv), .ser_tx_ready(str),
    .ser_tx_word_r(stw), .ser_tx_vld_r(stv), .clk_tx_pll_src(txs),
    .clk_rx_pll_src(rxs), .clk_gclk_src(gs), .clk_rclk_src(rs),
    .clk_iq_en(iqe), .clk_iq_ref(iqr), .clk_tx_pll_sel_r(txsel),
    .clk_rx_pll_sel_r(rxsel), .clk_gclk_sel_r(gsel), .clk_rclk_sel_r(rsel),
    .clk_iq_drv_r(iqd), .clk_route_err_r(rerr));
  tlb_assertions tlb_assertions_i (.ref_clk, .rst_b,
    .tx_data(lnk.tx_data), .tx_valid(lnk.tx_valid), .tx_ready(lnk.tx_ready),
    .rx_valid(lnk.rx_valid), .ser_lpbk_en(lnk.ser_lpbk_en),
    .pipe_lpbk(lnk.pipe_lpbk), .bist_err(lnk.bist_err),
    .bist_lock(lnk.bist_lock), .lb_active(lnk.lb_active));

  // Compares one value and counts it.
  task automatic chk(logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Moves to rising edges to drive, falling edges to sample.
  task automatic cyc(int k); repeat (k) @(posedge ref_clk); endtask
  task automatic smp(); @(negedge ref_clk); endtask

  // Puts one word on the line input and counts edges until it returns.
  task automatic lat(logic [19:0] v, output int k);
    srw <= v;
    k = 0;
    do begin
      cyc(1);
      k++;
      smp();
    end while (stw !== v && k < 9);
    cyc(1);
  endtask

  // Fills the buffer while the line stalls, then drains it in order.
  task automatic t_stream();
    int k;
    logic r;
    str <= 1'b0;
    for (k = 0; k < 40; k++) begin
      utd <= 20'h10000 + 20'(n);
      utv <= 1'b1;
      smp();
      r = utr;
      cyc(1);
      if (r) n++;
    end
    utv <= 1'b0;
    str <= 1'b1;
    cyc(1);
    smp();
    chk(n >= 16, 1);
    for (k = 0; k < 60;) begin
      if (stv) chk(stw, 32'h10000 + k);
      k += (stv === 1'b1) ? 1 : 60;
      smp();
    end
    cyc(1);
  endtask

  // Serial loop of a fabric word, then the PIPE mode paths and both reverse serial paths.
  task automatic t_serial();
    int k;
    usr <= 1'b1;
    cyc(3);
    utd <= 20'h5A5A5;
    utv <= 1'b1;
    smp();
    chk(ulb, TLB_LB_SERIAL);
    cyc(1);
    utv <= 1'b0;
    k = 0;
    do begin
      smp();
      k++;
    end while (urd !== 20'h5A5A5 && k < 20);
    chk({urv, urd}, {1'b1, 20'h5A5A5});
    cyc(1);
    usr <= 1'b0;
    cyc(2);
    pm <= 1'b1;
    upm <= 1'b1;
    usr <= 1'b1;
    cyc(4);
    upr <= 1'b1;
    smp();
    chk(ulb, TLB_LB_NONE);
    cyc(4);
    lat(20'hABCDE, k);
    chk(ulb, TLB_LB_PIPE_REV_PAR);
    chk(k, 2);
    usr <= 1'b0;
    upr <= 1'b0;
    cyc(3);
    pm <= 1'b0;
    upm <= 1'b0;
    lbc <= TLB_CFG_REV_SERIAL;
    srv <= 1'b1;
    cyc(3);
    lat(20'h12345, k);
    chk(k, 2);
    lbc <= TLB_CFG_REV_PRECDR;
    cyc(3);
    lat(20'h6789A, k);
    chk(k, 1);
  endtask

  // Parallel self-test at both widths; the word period names the pattern.
  task automatic t_bist();
    logic [19:0] q[$];
    logic [19:0] m;
    int i, p;
    for (i = 0; i < 2; i++) begin
      w20 <= (i == 0);
      dw <= 1'b1;
      lbc <= TLB_CFG_PARALLEL;
      p = (i == 0) ? 127 : 1023;
      m = (i == 0) ? 20'hFFFFF : 20'h003FF;
      cyc(3);
      smp();
      chk(ulb, TLB_LB_PARALLEL);
      q = {};
      repeat (p + 12) begin
        smp();
        q.push_back(urd);
      end
      if (i == 0) chk(q[10 + p], q[10]);
      else chk((q[137] & m) === (q[10] & m), 0);
      chk((q[10 + p] & m) === (q[10] & m), 1);
      chk({ubl, ube}, 2'b10);
      cyc(1);
      lbc <= TLB_CFG_NONE;
      cyc(3);
    end
    {dw, srv} <= '0;
    lbc <= TLB_CFG_PARALLEL;
    be <= 1'b1;
    cyc(3);
    smp();
    chk(ulb, TLB_LB_NONE);
    cyc(1);
    usr <= 1'b1;
    cyc(12);
    smp();
    chk({ubl, ube}, 2'b10);
    cyc(1);
    usr <= 1'b0;
  endtask

  // Legal routes take effect; illegal ones are flagged and ignored.
  task automatic t_clk();
    logic [3:0] bad[4] = '{TLB_CS_TXPLL0, TLB_CS_TXPLL1, TLB_CS_RXPLL0, 4'hA};
    txs[1] <= TLB_CS_REF1;
    rxs[3] <= TLB_CS_TXPLL1;
    rs <= TLB_CS_RXPLL3;
    gs <= TLB_CS_TXPLL0;
    iqe <= 1'b1;
    iqr <= 1'b1;
    cyc(2);
    smp();
    chk({txsel[1], rxsel[3]}, {TLB_CS_REF1, TLB_CS_TXPLL1});
    chk({rsel, gsel}, {TLB_CS_RXPLL3, TLB_CS_TXPLL0});
    chk({iqd, rerr}, 3'b100);
    foreach (bad[j]) begin
      cyc(1);
      txs[0] <= bad[j];
      cyc(2);
      smp();
      chk({txsel[0], rerr}, {TLB_CS_REF0, 1'b1});
    end
    cyc(1);
    txs[0] <= TLB_CS_GCLK;
    cyc(2);
    smp();
    chk({txsel[0], rerr}, {TLB_CS_REF0, 1'b1});
    cyc(1);
    ugp <= 1'b1;
    cyc(4);
    smp();
    chk({txsel[0], rerr}, {TLB_CS_GCLK, 1'b0});
  endtask

  // Clock source.
  initial forever #2 ref_clk = ~ref_clk;

  // Main sequence.
  initial begin
    {rst_b, pm, dw, w20, be, srv, str, iqe, iqr, utv, upm, usr, upr} = '0;
    {ugp, err_count, checked, n, utd, srw, gs, rs, txs, rxs} = '0;
    ce = 1'b1;
    lbc = TLB_CFG_NONE;
    cyc(16);
    rst_b <= 1'b1;
    cyc(2);
    t_stream();
    t_serial();
    t_bist();
    t_clk();
    stop_test();
  end
endmodule
